// ===== mcto_threshold_outputs.sv
// Operation
// - pos-error under closes when |err| <= threshold
// - pos-error over closes when |err| >= threshold
// - under filter closes after held longer than time
// - over filter: held at least time, drops immediately
// - settle time set per output by edit
// - in-position forced open during command or loss
// - velocity under closes when |vel| <= threshold
// - velocity over closes when |vel| >= threshold
// - torque under closes when |torque| <= threshold
// - torque over closes when |torque| >= threshold
// - thermal under closes when load <= threshold
// - thermal over closes when load >= threshold
// - closed when met, open otherwise; I_OUTPUT_INVERT inverts all eight condition flags
// - all thresholds zero after reset
// - thermal load at or above the limit for one sample raises warning A3
`timescale 1ns/1ps
`default_nettype none

module mcto_threshold_outputs #(
    parameter logic [13:0] THERM_LIMIT = mcto_pkg::THERM_WARN_LIMIT
) (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESETN,
    input  wire logic [22:0] I_POS_ERR,
    input  wire logic [15:0] I_VELOCITY,
    input  wire logic [15:0] I_TORQUE_CMD,
    input  wire logic [13:0] I_THERMAL_LOAD,
    input  wire logic        I_THR_WR,
    input  wire logic [2:0]  I_THR_SEL,
    input  wire logic [21:0] I_THR_DATA,
    input  wire logic        I_EDIT_OUTPUT_CMD,
    input  wire logic [2:0]  I_EDIT_SEL,
    input  wire logic [16:0] I_SETTLE_FILTER_TIME,
    input  wire logic        I_OUTPUT_INVERT,
    input  wire logic        I_MOTION_CMD_ACTIVE,
    input  wire logic        I_TARGET_LOST,
    input  wire logic        I_IN_POSITION_RAW,
    input  wire logic        I_WARN_CLEAR,
    output logic             O_POS_ERR_UNDER_FLAG,
    output logic             O_POS_ERR_OVER_FLAG,
    output logic             O_VEL_UNDER_FLAG,
    output logic             O_VEL_OVER_FLAG,
    output logic             O_TORQUE_UNDER_FLAG,
    output logic             O_TORQUE_OVER_FLAG,
    output logic             O_THERMAL_UNDER_FLAG,
    output logic             O_THERMAL_OVER_FLAG,
    output logic             O_IN_POSITION_OUT,
    output logic             O_THERMAL_WARN,
    output logic [7:0]       O_WARN_CODE
);
    typedef struct packed {
        logic [7:0][21:0] thr_reg;
        logic [7:0][16:0] settle_reg;
        logic [10:0]      tick_reg;
        logic [7:0]       flag_reg;
        logic             in_pos_reg;
        logic             warn_reg;
        logic [7:0]       code_reg;
    } mcto_state_t;

    mcto_state_t st_reg;
    mcto_state_t st_next;
    logic        tick;
    logic [21:0] pe_abs;
    logic [21:0] vel_abs;
    logic [21:0] trq_abs;
    logic [21:0] thm_ext;
    logic [7:0]  raw_cond;
    logic [7:0]  met;

    // magnitude of a signed value, saturating at the top code
    function automatic logic [21:0] mcto_abs(input logic [22:0] v);
        logic [22:0] m;
        m = v[22] ? (~v + 23'h000001) : v;
        if (m[22]) begin
            return 22'h3fffff;
        end
        return m[21:0];
    endfunction

    // limit a threshold to the range of its quantity
    function automatic logic [21:0] mcto_clamp_thr(input logic [2:0] sel,
                                                   input logic [21:0] d);
        logic [21:0] lim;
        if (sel == mcto_pkg::IDX_PE_UNDER || sel == mcto_pkg::IDX_PE_OVER) begin
            lim = mcto_pkg::PE_THR_MAX;
        end else if (sel == mcto_pkg::IDX_VEL_UNDER || sel == mcto_pkg::IDX_VEL_OVER) begin
            lim = mcto_pkg::VEL_THR_MAX;
        end else begin
            lim = mcto_pkg::PCT_THR_MAX;
        end
        return (d > lim) ? lim : d;
    endfunction

    // magnitudes of the monitored quantities
    assign pe_abs  = mcto_abs(I_POS_ERR);
    assign vel_abs = mcto_abs({{7{I_VELOCITY[15]}}, I_VELOCITY});
    assign trq_abs = mcto_abs({{7{I_TORQUE_CMD[15]}}, I_TORQUE_CMD});
    assign thm_ext = {8'h00, I_THERMAL_LOAD};

    // raw threshold comparisons, every sample
    always_comb begin
        raw_cond[0] = pe_abs  <= st_reg.thr_reg[mcto_pkg::IDX_PE_UNDER];
        raw_cond[1] = pe_abs  >= st_reg.thr_reg[mcto_pkg::IDX_PE_OVER];
        raw_cond[2] = vel_abs <= st_reg.thr_reg[mcto_pkg::IDX_VEL_UNDER];
        raw_cond[3] = vel_abs >= st_reg.thr_reg[mcto_pkg::IDX_VEL_OVER];
        raw_cond[4] = trq_abs <= st_reg.thr_reg[mcto_pkg::IDX_TRQ_UNDER];
        raw_cond[5] = trq_abs >= st_reg.thr_reg[mcto_pkg::IDX_TRQ_OVER];
        raw_cond[6] = thm_ext <= st_reg.thr_reg[mcto_pkg::IDX_THM_UNDER];
        raw_cond[7] = thm_ext >= st_reg.thr_reg[mcto_pkg::IDX_THM_OVER];
    end

    // settle time unit strobe
    assign tick = st_reg.tick_reg == mcto_pkg::TICK_LAST;

    // one settle filter per condition output, under ones strict
    for (genvar g = 0; g < 8; g++) begin : g_filt
        mcto_settle_filter #(
            .STRICT ((g % 2) == 0)
        ) u_filt (
            .i_clock  (I_CLOCK),
            .i_resetn (I_RESETN),
            .i_cond   (raw_cond[g]),
            .i_tick   (tick),
            .i_time   (st_reg.settle_reg[g]),
            .o_met    (met[g])
        );
    end

    // next state: settings, output flags, warning
    always_comb begin
        st_next = st_reg;
        st_next.tick_reg = tick ? 11'h000 : st_reg.tick_reg + 11'h001;
        if (I_THR_WR) begin
            st_next.thr_reg[I_THR_SEL] = mcto_clamp_thr(I_THR_SEL, I_THR_DATA);
        end
        if (I_EDIT_OUTPUT_CMD) begin
            st_next.settle_reg[I_EDIT_SEL] = (I_SETTLE_FILTER_TIME > mcto_pkg::SETTLE_TIME_MAX)
                ? mcto_pkg::SETTLE_TIME_MAX : I_SETTLE_FILTER_TIME;
        end
        st_next.flag_reg   = met ^ {8{I_OUTPUT_INVERT}};
        st_next.in_pos_reg = I_IN_POSITION_RAW && !I_MOTION_CMD_ACTIVE
                             && !I_TARGET_LOST;
        // set beats clear
        st_next.warn_reg = (I_THERMAL_LOAD >= THERM_LIMIT)
                           || (st_reg.warn_reg && !I_WARN_CLEAR);
        st_next.code_reg = st_next.warn_reg ? mcto_pkg::WARN_CODE_THERMAL
                                            : mcto_pkg::WARN_CODE_NONE;
    end

    // state register, thresholds and times zero at reset
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign O_POS_ERR_UNDER_FLAG = st_reg.flag_reg[0];
    assign O_POS_ERR_OVER_FLAG  = st_reg.flag_reg[1];
    assign O_VEL_UNDER_FLAG     = st_reg.flag_reg[2];
    assign O_VEL_OVER_FLAG      = st_reg.flag_reg[3];
    assign O_TORQUE_UNDER_FLAG  = st_reg.flag_reg[4];
    assign O_TORQUE_OVER_FLAG   = st_reg.flag_reg[5];
    assign O_THERMAL_UNDER_FLAG = st_reg.flag_reg[6];
    assign O_THERMAL_OVER_FLAG  = st_reg.flag_reg[7];
    assign O_IN_POSITION_OUT    = st_reg.in_pos_reg;
    assign O_THERMAL_WARN       = st_reg.warn_reg;
    assign O_WARN_CODE          = st_reg.code_reg;

    // checks on the outputs, settings and settle tick
    property p_pe_under;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (st_reg.settle_reg[0] == 17'h00000 && !I_OUTPUT_INVERT)
            |=> O_POS_ERR_UNDER_FLAG == $past(raw_cond[0]);
    endproperty
    a_pe_under: assert property (p_pe_under) else $error("pos under flag wrong");

    property p_pe_over;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (st_reg.settle_reg[1] == 17'h00000 && !I_OUTPUT_INVERT && raw_cond[1])
            |=> O_POS_ERR_OVER_FLAG;
    endproperty
    a_pe_over: assert property (p_pe_over) else $error("pos over flag not closed");

    property p_under_waits;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (raw_cond[0] && !$past(raw_cond[0]) && st_reg.settle_reg[0] != 17'h00000
         && !I_OUTPUT_INVERT) |=> !O_POS_ERR_UNDER_FLAG;
    endproperty
    a_under_waits: assert property (p_under_waits) else $error("under closed early");

    property p_over_drops;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (!raw_cond[1] && !I_OUTPUT_INVERT) |=> !O_POS_ERR_OVER_FLAG;
    endproperty
    a_over_drops: assert property (p_over_drops) else $error("over flag stayed closed");

    property p_over_waits;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (raw_cond[1] && !$past(raw_cond[1]) && st_reg.settle_reg[1] != 17'h00000
         && !I_OUTPUT_INVERT) |=> !O_POS_ERR_OVER_FLAG;
    endproperty
    a_over_waits: assert property (p_over_waits) else $error("over closed early");

    property p_edit;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (I_EDIT_OUTPUT_CMD && I_SETTLE_FILTER_TIME <= mcto_pkg::SETTLE_TIME_MAX)
            |=> st_reg.settle_reg[$past(I_EDIT_SEL)] == $past(I_SETTLE_FILTER_TIME);
    endproperty
    a_edit: assert property (p_edit) else $error("settle time not stored");

    property p_inpos_forced;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (I_MOTION_CMD_ACTIVE || I_TARGET_LOST) |=> !O_IN_POSITION_OUT;
    endproperty
    a_inpos_forced: assert property (p_inpos_forced) else $error("in-position not open");

    property p_vel;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (st_reg.settle_reg[2] == 17'h00000 && st_reg.settle_reg[3] == 17'h00000
         && !I_OUTPUT_INVERT) |=> {O_VEL_OVER_FLAG, O_VEL_UNDER_FLAG} == $past(raw_cond[3:2]);
    endproperty
    a_vel: assert property (p_vel) else $error("velocity flags wrong");

    property p_trq;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (st_reg.settle_reg[4] == 17'h00000 && !I_OUTPUT_INVERT && trq_abs == 22'h000000)
            |=> O_TORQUE_UNDER_FLAG;
    endproperty
    a_trq: assert property (p_trq) else $error("torque under open at zero");

    property p_trq_over;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (st_reg.settle_reg[5] == 17'h00000 && !I_OUTPUT_INVERT)
            |=> O_TORQUE_OVER_FLAG == $past(raw_cond[5]);
    endproperty
    a_trq_over: assert property (p_trq_over) else $error("torque over flag wrong");

    property p_thm;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (st_reg.settle_reg[6] == 17'h00000 && st_reg.settle_reg[7] == 17'h00000
         && !I_OUTPUT_INVERT) |=> {O_THERMAL_OVER_FLAG, O_THERMAL_UNDER_FLAG}
                                  == $past(raw_cond[7:6]);
    endproperty
    a_thm: assert property (p_thm) else $error("thermal flags wrong");

    property p_invert;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        I_OUTPUT_INVERT |=> O_VEL_UNDER_FLAG == !$past(met[2]);
    endproperty
    a_invert: assert property (p_invert) else $error("polarity not applied");

    property p_reset_thr;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        $rose(I_RESETN) |-> st_reg.thr_reg == '0 && st_reg.settle_reg == '0;
    endproperty
    a_reset_thr: assert property (p_reset_thr) else $error("threshold not zero");

    property p_warn;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        (I_THERMAL_LOAD >= THERM_LIMIT) |=> O_THERMAL_WARN
            && O_WARN_CODE == mcto_pkg::WARN_CODE_THERMAL;
    endproperty
    a_warn: assert property (p_warn) else $error("thermal warning missing");

    property p_tick;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        tick |=> !tick [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("settle tick too frequent");

    // main scenarios
    c_under_filtered: cover property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        st_reg.settle_reg[0] != 17'h00000 && $rose(O_POS_ERR_UNDER_FLAG));
    c_inpos_forced: cover property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        I_IN_POSITION_RAW && I_MOTION_CMD_ACTIVE);
    c_warn_clear: cover property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        $fell(O_THERMAL_WARN));
    c_over_filtered: cover property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        st_reg.settle_reg[1] != 17'h00000 && $fell(O_POS_ERR_OVER_FLAG));
endmodule

`default_nettype wire

// ===== mcto_pkg.sv
`timescale 1ns/1ps
`default_nettype none

package mcto_pkg;
    // widths of stored thresholds and settle times
    localparam int THR_W  = 22;
    localparam int TIME_W = 17;
    localparam int TICK_W = 11;
    // threshold ranges and values after reset
    localparam logic [21:0] PE_THR_MAX  = 22'h27ffff; // 2 621 439 pulses
    localparam logic [21:0] VEL_THR_MAX = 22'h002710; // 10.000 rev/s in 0.001 units
    localparam logic [21:0] PCT_THR_MAX = 22'h002710; // 100.00 % in 0.01 units
    localparam logic [21:0] THR_RESET   = 22'h000000;
    localparam logic [16:0] TIME_RESET  = 17'h00000;
    // settle time range, 0.0 to 10 000.0 ms in 0.1 ms units
    localparam logic [16:0] SETTLE_TIME_MAX = 17'h186a0;
    // settle time unit and its length in clock cycles
    localparam int CLOCK_PERIOD_NS  = 50;
    localparam int SETTLE_UNIT_NS   = 100000;
    localparam int TICK_CYCLES      = SETTLE_UNIT_NS / CLOCK_PERIOD_NS;
    localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);
    // condition output indices
    localparam logic [2:0] IDX_PE_UNDER  = 3'h0;
    localparam logic [2:0] IDX_PE_OVER   = 3'h1;
    localparam logic [2:0] IDX_VEL_UNDER = 3'h2;
    localparam logic [2:0] IDX_VEL_OVER  = 3'h3;
    localparam logic [2:0] IDX_TRQ_UNDER = 3'h4;
    localparam logic [2:0] IDX_TRQ_OVER  = 3'h5;
    localparam logic [2:0] IDX_THM_UNDER = 3'h6;
    localparam logic [2:0] IDX_THM_OVER  = 3'h7;
    // thermal warning code and default trip level, 100.00 %
    localparam logic [7:0]  WARN_CODE_THERMAL = 8'ha3;
    localparam logic [7:0]  WARN_CODE_NONE    = 8'h00;
    localparam logic [13:0] THERM_WARN_LIMIT  = 14'h2710;
endpackage

module mcto_settle_filter #(
    parameter bit STRICT = 1'b1
) (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_cond,
    input  wire logic        i_tick,
    input  wire logic [16:0] i_time,
    output logic             o_met
);
    typedef struct packed {
        logic [16:0] held_reg;
    } mcto_filt_state_t;

    mcto_filt_state_t st_reg;
    mcto_filt_state_t st_next;
    logic             long_enough;

    // hold counter, cleared as soon as the condition drops
    always_comb begin
        st_next = st_reg;
        if (!i_cond) begin
            st_next.held_reg = mcto_pkg::TIME_RESET;
        end else if (i_tick && st_reg.held_reg <= mcto_pkg::SETTLE_TIME_MAX) begin
            // count one past the top time so a strict filter at the top still closes
            st_next.held_reg = st_reg.held_reg + 17'h00001;
        end
        if (STRICT) begin
            long_enough = st_reg.held_reg > i_time;
        end else begin
            long_enough = st_reg.held_reg >= i_time;
        end
        o_met = i_cond && (i_time == mcto_pkg::TIME_RESET || long_enough);
    end

    // state register
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

`default_nettype wire

// ===== mcto_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module mcto_host_model (
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic i_thermal_under_flag,
    output logic      o_cycle_ok
);
    logic cycle_ok_reg;

    // next cycle allowed only while the zero-load flag reads closed
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cycle_ok_reg <= 1'b0;
        end else begin
            cycle_ok_reg <= i_thermal_under_flag;
        end
    end

    assign o_cycle_ok = cycle_ok_reg;
endmodule

`default_nettype wire

// ===== motor_condition_threshold_outputs_test.sv
`timescale 1ns/1ps
`default_nettype none

module motor_condition_threshold_outputs_test;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [22:0] pos_err = 23'h000000;
    logic [15:0] vel = 16'h0000;
    logic [15:0] trq = 16'h0000;
    logic [13:0] thm = 14'h0000;
    logic        thr_wr = 1'b0;
    logic [2:0]  thr_sel = 3'h0;
    logic [21:0] thr_data = 22'h000000;
    logic        edit = 1'b0;
    logic [2:0]  edit_sel = 3'h0;
    logic [16:0] stime = 17'h00000;
    logic        inv = 1'b0;
    logic        cmd = 1'b0;
    logic        lost = 1'b0;
    logic        raw = 1'b0;
    logic        wclr = 1'b0;
    wire [7:0]   flags;
    logic        in_position_out;
    logic        warn;
    logic        cycle_ok;
    logic [7:0]  code;
    int          failures = 0;
    int          num_checks = 0;
    int          t;
    int          v;

    // 20 MHz clock
    always #25 clk = ~clk;

    mcto_threshold_outputs dut (
        .I_CLOCK(clk), .I_RESETN(rstn), .I_POS_ERR(pos_err), .I_VELOCITY(vel),
        .I_TORQUE_CMD(trq), .I_THERMAL_LOAD(thm), .I_THR_WR(thr_wr), .I_THR_SEL(thr_sel),
        .I_THR_DATA(thr_data), .I_EDIT_OUTPUT_CMD(edit), .I_EDIT_SEL(edit_sel),
        .I_SETTLE_FILTER_TIME(stime), .I_OUTPUT_INVERT(inv), .I_MOTION_CMD_ACTIVE(cmd),
        .I_TARGET_LOST(lost), .I_IN_POSITION_RAW(raw), .I_WARN_CLEAR(wclr),
        .O_POS_ERR_UNDER_FLAG(flags[0]), .O_POS_ERR_OVER_FLAG(flags[1]),
        .O_VEL_UNDER_FLAG(flags[2]), .O_VEL_OVER_FLAG(flags[3]),
        .O_TORQUE_UNDER_FLAG(flags[4]), .O_TORQUE_OVER_FLAG(flags[5]),
        .O_THERMAL_UNDER_FLAG(flags[6]), .O_THERMAL_OVER_FLAG(flags[7]),
        .O_IN_POSITION_OUT(in_position_out), .O_THERMAL_WARN(warn), .O_WARN_CODE(code)
    );

    mcto_host_model host (
        .i_clock(clk), .i_resetn(rstn), .i_thermal_under_flag(flags[6]),
        .o_cycle_ok(cycle_ok)
    );

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // let n edges pass, then sample settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic write_thr(input logic [2:0] sel, input logic [21:0] d);
        @(posedge clk);
        thr_wr <= 1'b1;
        thr_sel <= sel;
        thr_data <= d;
        @(posedge clk);
        thr_wr <= 1'b0;
    endtask

    task automatic write_time(input logic [2:0] sel, input logic [16:0] d);
        @(posedge clk);
        edit <= 1'b1;
        edit_sel <= sel;
        stime <= d;
        @(posedge clk);
        edit <= 1'b0;
    endtask

    // k: 0 position error, 1 velocity, 2 torque, 3 thermal load
    task automatic set_qty(input int k, input int val);
        @(posedge clk);
        case (k)
            0: pos_err <= 23'(val);
            1: vel <= 16'(val);
            2: trq <= 16'(val);
            default: thm <= 14'(val);
        endcase
    endtask

    // bounded wait for a filtered flag to close
    task automatic wait_flag(input int idx);
        int n;
        n = 0;
        while (flags[idx] !== 1'b1 && n < 6500) begin
            @(posedge clk);
            #1;
            n++;
        end
        num_checks++;
        if (n >= 6500) begin
            failures++;
            $display("ERROR filtered flag %0d expected 1 seen %b", idx, flags[idx]);
            stop_test();
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        tick(2);
        check("flags after reset", 8'hff, flags);
        @(posedge clk);
        inv <= 1'b1;
        tick(2);
        check("inverted flags", 8'h00, flags);
        @(posedge clk);
        inv <= 1'b0;
        // each quantity at, below and above a clamped threshold, and mirrored except thermal load, set to 0
        for (int k = 0; k < 4; k++) begin
            t = (k == 0) ? 2621439 : 10000;
            write_thr(3'(2 * k), 22'h3fffff);
            write_thr(3'(2 * k + 1), 22'h3fffff);
            for (int j = 0; j < 4; j++) begin
                v = (j == 3) ? ((k == 3) ? 0 : -t) : t - 1 + j;
                set_qty(k, v);
                tick(2);
                if (v < 0) v = -v;
                check("under flag", v <= t, flags[2 * k]);
                check("over flag", v >= t, flags[2 * k + 1]);
            end
        end
        // in-position gating; position flags keep raw compare meanwhile
        for (int j = 0; j < 3; j++) begin
            @(posedge clk);
            raw <= 1'b1;
            cmd <= (j == 1);
            lost <= (j == 2);
            tick(2);
            check("in position", j == 0, in_position_out);
            check("pos flags", 2'b11, flags[1:0]);
        end
        // thermal warning and host wait for zero load
        write_thr(3'h6, 22'h000000);
        set_qty(3, 10000);
        tick(3);
        check("warning", 1'b1, warn);
        check("warning code", 8'ha3, code);
        check("cycle ok loaded", 1'b0, cycle_ok);
        set_qty(3, 0);
        @(posedge clk);
        wclr <= 1'b1;
        @(posedge clk);
        wclr <= 1'b0;
        tick(3);
        check("warning cleared", 8'h00, code);
        check("warning flag cleared", 1'b0, warn);
        check("cycle ok idle", 1'b1, cycle_ok);
        // over flag with settle time 2, opened by a one-cycle dip
        write_time(3'h1, 17'h00002);
        set_qty(0, 0);
        set_qty(0, 2621439);
        tick(1500);
        check("over filtered early", 1'b0, flags[1]);
        wait_flag(1);
        set_qty(0, 5);
        set_qty(0, 2621439);
        tick(1);
        check("over dip opens", 1'b0, flags[1]);
        // under flag with settle time 1 needs more than one tick
        write_time(3'h0, 17'h00001);
        set_qty(0, 2621440);
        set_qty(0, 0);
        tick(1500);
        check("under filtered early", 1'b0, flags[0]);
        wait_flag(0);
        check("unfiltered velocity", 1'b1, flags[2]);
        stop_test();
    end
endmodule

`default_nettype wire
